//--- hw/ebp_params.svh
`ifndef EBP_PARAMS_SVH
`define EBP_PARAMS_SVH
`define EBP_OFS_DUTY_LOW 8'h00
`define EBP_OFS_CTRL 8'h04
`define EBP_OFS_PERIOD 8'h08
`define EBP_OFS_TIMER 8'h0c
`define EBP_OFS_SHADOW 8'h10
`define EBP_OFS_SHUTDOWN 8'h14
`define EBP_OFS_DELAY 8'h18
`define EBP_OFS_TCTL 8'h1c
`define EBP_CTL_DIR 7
`define EBP_CTL_FULL 6
`define EBP_CTL_CFG 7:6
`define EBP_CTL_LSB 5:4
`define EBP_CTL_MODE 3:2
`define EBP_CTL_POL 1:0
`define EBP_POL_AC 1
`define EBP_POL_BD 0
`define EBP_MODE_PWM 2'h3
`define EBP_SD_STS 7
`define EBP_SD_SRC 6:4
`define EBP_SD_AC 3:2
`define EBP_SD_BD 1:0
`define EBP_DEL_RSEN 7
`define EBP_DEL_CNT 6:0
`define EBP_TC_ON 2
`define EBP_TC_PS 1:0
`define EBP_REG_RST 8'h00
`define EBP_PERIOD_RST 8'hff
`define EBP_RESP_OKAY 2'h0
`define EBP_RESP_SLVERR 2'h2
`define EBP_PS_DIV1 1
`define EBP_PS_DIV4 4
`define EBP_PS_DIV16 16
`define EBP_TOSC_NS 25
`define EBP_TCY_NS 100
`define EBP_TCY_CLKS ((`EBP_TCY_NS + `EBP_TOSC_NS - 1) / `EBP_TOSC_NS)
`endif

//--- hw/ebp_pkg.sv
package ebp_pkg;
  typedef enum logic [1:0] {
    EBP_CFG_SINGLE = 2'h0,
    EBP_CFG_FWD = 2'h1,
    EBP_CFG_HALF = 2'h2,
    EBP_CFG_REV = 2'h3
  } ebp_cfg_e;
  typedef enum logic {
    EBP_WR_IDLE = 1'h0,
    EBP_WR_RESP = 1'h1
  } ebp_wr_e;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } ebp_pins_s;
  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] filt;
    logic [7:0] duty_low;
    logic [7:0] ctrl;
    logic [7:0] period;
    logic [7:0] timer;
    logic [7:0] shadow;
    logic [1:0] latch;
    logic [6:0] sdctl;
    logic status;
    logic [7:0] delcfg;
    logic [2:0] tctl;
    logic [5:0] fine;
    ebp_cfg_e act_cfg;
    logic [1:0] act_pol;
    logic [6:0] act_del;
    logic pwm;
    logic shut_period;
    logic ev_prev;
    logic [1:0][8:0] dcnt;
    ebp_pins_s pins;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wen;
    ebp_wr_e wst;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ebp_state_s;
endpackage

//--- hw/ebp_bridge_pwm.sv
`timescale 1ns/1ps
`include "ebp_params.svh"
`default_nettype none
module ebp_bridge_pwm
  import ebp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic comp1_in,
  input wire logic comp2_in,
  input wire logic fault_input,
  output var ebp_pins_s pins
);
  ebp_state_s st_ff;
  ebp_state_s nxt_st;
  logic pwm_mode;
  logic tmr_on;
  logic [5:0] fine_lim;
  logic [1:0] sub;
  logic fine_last;
  logic q_last;
  logic at_limit;
  logic pstart;
  logic match;
  logic ev;
  logic forced;
  logic chg;
  logic [8:0] db_lim;
  logic [1:0] db_out;
  logic [3:0] act;
  logic [3:0] used;

  assign pwm_mode = st_ff.ctrl[`EBP_CTL_MODE] == `EBP_MODE_PWM;
  assign tmr_on = st_ff.tctl[`EBP_TC_ON];
  always_comb begin
    if (st_ff.tctl[`EBP_TC_PS] == 2'h0) begin
      fine_lim = 6'(`EBP_TCY_CLKS * `EBP_PS_DIV1 - 1);
      sub = st_ff.fine[1:0];
      q_last = 1'h1;
    end else if (st_ff.tctl[`EBP_TC_PS] == 2'h1) begin
      fine_lim = 6'(`EBP_TCY_CLKS * `EBP_PS_DIV4 - 1);
      sub = st_ff.fine[3:2];
      q_last = st_ff.fine[1:0] == 2'h3;
    end else begin
      fine_lim = 6'(`EBP_TCY_CLKS * `EBP_PS_DIV16 - 1);
      sub = st_ff.fine[5:4];
      q_last = st_ff.fine[3:0] == 4'hf;
    end
  end
  assign fine_last = tmr_on && (st_ff.fine >= fine_lim);
  assign at_limit = tmr_on && (st_ff.timer == st_ff.period);
  assign pstart = fine_last && at_limit;
  // Quarter-steps of one timer tick extend the compare to ten bits
  // Clearing on the last clock of the step before the duty value keeps the high time at exactly D steps
  assign match = tmr_on && q_last && ({st_ff.shadow, st_ff.latch} == ({st_ff.timer, sub} + 10'h001));
  assign ev = pwm_mode && |(st_ff.sdctl[`EBP_SD_SRC] & st_ff.filt);
  // Live event forces pins before the status flop catches up
  assign forced = pwm_mode && (ev || st_ff.status || st_ff.shut_period);
  assign chg = at_limit && st_ff.act_cfg[0] && st_ff.ctrl[`EBP_CTL_FULL]
    && (st_ff.ctrl[`EBP_CTL_DIR] != st_ff.act_cfg[1]);
  assign db_lim = 9'(st_ff.act_del * `EBP_TCY_CLKS);
  assign db_out[0] = st_ff.pwm && (st_ff.dcnt[0] >= db_lim);
  assign db_out[1] = !st_ff.pwm && (st_ff.dcnt[1] >= db_lim);

  always_comb begin
    used = 4'h0;
    act = 4'h0;
    case (st_ff.act_cfg)
      EBP_CFG_SINGLE: begin
        used = 4'h1;
        act = {3'h0, st_ff.pwm};
      end
      EBP_CFG_HALF: begin
        used = 4'h3;
        act = {2'h0, db_out};
      end
      EBP_CFG_FWD: begin
        used = 4'hf;
        act = {st_ff.pwm, 2'h0, 1'h1};
      end
      default: begin
        used = 4'hf;
        act = {1'h0, 1'h1, st_ff.pwm, 1'h0};
      end
    endcase
    if (chg) begin
      act = {1'h0, st_ff.ctrl[`EBP_CTL_DIR], 1'h0, !st_ff.ctrl[`EBP_CTL_DIR]};
    end
  end

  always_comb begin
    logic aw_h;
    logic w_h;
    logic [7:0] wa;
    logic [7:0] wd;
    logic do_wr;
    logic sts_wr;
    logic [1:0] ss;
    logic pol;
    aw_h = 1'h0;
    w_h = 1'h0;
    wa = 8'h00;
    wd = 8'h00;
    do_wr = 1'h0;
    sts_wr = 1'h0;
    ss = 2'h0;
    pol = 1'h0;
    nxt_st = st_ff;
    nxt_st.sy1 = {fault_input, comp2_in, comp1_in};
    nxt_st.sy2 = st_ff.sy1;
    nxt_st.sy3 = st_ff.sy2;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.sy2[i] == st_ff.sy3[i]) begin
        nxt_st.filt[i] = st_ff.sy2[i];
      end
    end
    // Write address and data may arrive in either order
    aw_h = st_ff.aw_got || (awvalid && awready);
    w_h = st_ff.w_got || (wvalid && wready);
    wa = st_ff.aw_got ? st_ff.awaddr : awaddr;
    wd = st_ff.w_got ? st_ff.wdata : wdata[7:0];
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'h1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'h1;
      nxt_st.wdata = wdata[7:0];
      nxt_st.wen = wstrb[0];
    end
    if (st_ff.wst == EBP_WR_RESP && bready) begin
      nxt_st.wst = EBP_WR_IDLE;
    end
    if (aw_h && w_h && st_ff.wst == EBP_WR_IDLE) begin
      do_wr = st_ff.w_got ? st_ff.wen : wstrb[0];
      nxt_st.aw_got = 1'h0;
      nxt_st.w_got = 1'h0;
      nxt_st.wst = EBP_WR_RESP;
      nxt_st.bresp = `EBP_RESP_OKAY;
      if (wa == `EBP_OFS_DUTY_LOW) begin
        if (do_wr) nxt_st.duty_low = wd;
      end else if (wa == `EBP_OFS_CTRL) begin
        if (do_wr) nxt_st.ctrl = wd;
      end else if (wa == `EBP_OFS_PERIOD) begin
        if (do_wr) nxt_st.period = wd;
      end else if (wa == `EBP_OFS_SHUTDOWN) begin
        if (do_wr) begin
          nxt_st.sdctl = wd[6:0];
          sts_wr = 1'h1;
        end
      end else if (wa == `EBP_OFS_DELAY) begin
        if (do_wr) nxt_st.delcfg = wd;
      end else if (wa == `EBP_OFS_TCTL) begin
        if (do_wr) nxt_st.tctl = wd[2:0];
      end else if (wa == `EBP_OFS_TIMER || wa == `EBP_OFS_SHADOW) begin
        nxt_st.bresp = `EBP_RESP_OKAY;
      end else begin
        nxt_st.bresp = `EBP_RESP_SLVERR;
      end
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'h0;
    end
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'h1;
      nxt_st.rresp = `EBP_RESP_OKAY;
      if (araddr == `EBP_OFS_DUTY_LOW) begin
        nxt_st.rdata = st_ff.duty_low;
      end else if (araddr == `EBP_OFS_CTRL) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (araddr == `EBP_OFS_PERIOD) begin
        nxt_st.rdata = st_ff.period;
      end else if (araddr == `EBP_OFS_TIMER) begin
        nxt_st.rdata = st_ff.timer;
      end else if (araddr == `EBP_OFS_SHADOW) begin
        nxt_st.rdata = st_ff.shadow;
      end else if (araddr == `EBP_OFS_SHUTDOWN) begin
        nxt_st.rdata = {st_ff.status, st_ff.sdctl};
      end else if (araddr == `EBP_OFS_DELAY) begin
        nxt_st.rdata = st_ff.delcfg;
      end else if (araddr == `EBP_OFS_TCTL) begin
        nxt_st.rdata = {5'h00, st_ff.tctl};
      end else begin
        nxt_st.rdata = 8'h00;
        nxt_st.rresp = `EBP_RESP_SLVERR;
      end
    end
    // Period timer and prescaler
    if (tmr_on) begin
      if (fine_last) begin
        nxt_st.fine = 6'h00;
        nxt_st.timer = pstart ? 8'h00 : st_ff.timer + 8'h01;
      end else begin
        nxt_st.fine = st_ff.fine + 6'h01;
      end
    end
    if (pstart) begin
      nxt_st.shadow = st_ff.duty_low;
      nxt_st.latch = st_ff.ctrl[`EBP_CTL_LSB];
      nxt_st.act_cfg = ebp_cfg_e'(st_ff.ctrl[`EBP_CTL_CFG]);
      nxt_st.act_pol = st_ff.ctrl[`EBP_CTL_POL];
      nxt_st.act_del = st_ff.delcfg[`EBP_DEL_CNT];
      nxt_st.shut_period = st_ff.status;
      nxt_st.pwm = {st_ff.duty_low, st_ff.ctrl[`EBP_CTL_LSB]} != 10'h000;
    end else if (match) begin
      nxt_st.pwm = 1'h0;
      nxt_st.act_del = st_ff.delcfg[`EBP_DEL_CNT];
    end
    // Dead-band counters restart on every inactive phase
    for (int i = 0; i < 2; i++) begin
      if ((i == 0) ? !st_ff.pwm : st_ff.pwm) begin
        nxt_st.dcnt[i] = 9'h000;
      end else if (st_ff.dcnt[i] < db_lim) begin
        nxt_st.dcnt[i] = st_ff.dcnt[i] + 9'h001;
      end
    end
    // Set beats any clear in the same cycle
    if (sts_wr && !ev) begin
      nxt_st.status = wd[`EBP_SD_STS];
    end
    if (st_ff.delcfg[`EBP_DEL_RSEN] && st_ff.ev_prev && !ev) begin
      nxt_st.status = 1'h0;
    end
    if (ev) begin
      nxt_st.status = 1'h1;
    end
    nxt_st.ev_prev = ev;
    for (int i = 0; i < 4; i++) begin
      ss = i[0] ? st_ff.sdctl[`EBP_SD_BD] : st_ff.sdctl[`EBP_SD_AC];
      pol = i[0] ? st_ff.act_pol[`EBP_POL_BD] : st_ff.act_pol[`EBP_POL_AC];
      if (!pwm_mode) begin
        nxt_st.pins.out[i] = 1'h0;
        nxt_st.pins.oe[i] = 1'h0;
      end else if (forced) begin
        nxt_st.pins.out[i] = used[i] && ss[0];
        nxt_st.pins.oe[i] = used[i] && !ss[1];
      end else begin
        nxt_st.pins.out[i] = used[i] && (act[i] ^ pol);
        nxt_st.pins.oe[i] = used[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.period <= `EBP_PERIOD_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign awready = !st_ff.aw_got && st_ff.wst == EBP_WR_IDLE;
  assign wready = !st_ff.w_got && st_ff.wst == EBP_WR_IDLE;
  assign bvalid = st_ff.wst == EBP_WR_RESP;
  assign bresp = st_ff.bresp;
  assign arready = !st_ff.rvalid;
  assign rvalid = st_ff.rvalid;
  assign rdata = {24'h000000, st_ff.rdata};
  assign rresp = st_ff.rresp;
  assign pins = st_ff.pins;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_shadow_load;
    ce && pstart |=> st_ff.shadow == $past(st_ff.duty_low) && st_ff.latch == $past(st_ff.ctrl[5:4]);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded at period end");

  property p_shadow_ro;
    !pstart |=> $stable(st_ff.shadow);
  endproperty
  a_shadow_ro: assert property (p_shadow_ro) else $error("shadow changed off boundary");

  property p_match_clear;
    ce && st_ff.pwm && match && !pstart |=> !st_ff.pwm;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("pwm not cleared on match");

  property p_over_duty;
    st_ff.pwm && !pstart && ({st_ff.shadow, st_ff.latch} > {st_ff.period, 2'h3}) |=> st_ff.pwm;
  endproperty
  a_over_duty: assert property (p_over_duty) else $error("long duty cleared output");

  property p_deadband;
    ce && pwm_mode && !forced && st_ff.act_cfg == EBP_CFG_HALF && st_ff.pwm && !db_out[0]
      |=> st_ff.pins.out[0] == st_ff.act_pol[1] ##1 1;
  endproperty
  a_deadband: assert property (p_deadband) else $error("A active inside dead band");

  property p_forward;
    ce && pwm_mode && !forced && !chg && st_ff.act_cfg == EBP_CFG_FWD
      |=> st_ff.pins.out[0] != st_ff.act_pol[1] && st_ff.pins.out[2] == st_ff.act_pol[1];
  endproperty
  a_forward: assert property (p_forward) else $error("forward levels wrong");

  sequence s_dir_window;
    ce && pwm_mode && !forced && chg;
  endsequence
  sequence s_mod_off;
    st_ff.pins.out[1] == st_ff.act_pol[0] && st_ff.pins.out[3] == st_ff.act_pol[0];
  endsequence
  property p_dir_change;
    s_dir_window |=> s_mod_off;
  endproperty
  a_dir_change: assert property (p_dir_change) else $error("modulated pin active in swap");

  property p_shutdown;
    ce && ev |=> st_ff.status && st_ff.pins.oe[0] == !st_ff.sdctl[3]
      && st_ff.pins.out[0] == st_ff.sdctl[2];
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("pins not in shutdown state");

  property p_sts_locked;
    ce && ev && st_ff.status |=> st_ff.status;
  endproperty
  a_sts_locked: assert property (p_sts_locked) else $error("status cleared during event");

  property p_freeze;
    !ce |=> $stable(st_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_idle_pins;
    ce && !pwm_mode |=> st_ff.pins.oe == 4'h0;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pin driven outside pwm mode");

  property p_deadband_b;
    ce && pwm_mode && !forced && !pstart && st_ff.act_cfg == EBP_CFG_HALF && !st_ff.pwm && !db_out[1]
      |=> st_ff.pins.out[1] == st_ff.act_pol[0];
  endproperty
  a_deadband_b: assert property (p_deadband_b) else $error("B active inside dead band");
endmodule
`default_nettype wire

//--- test/ebp_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebp_switch_model
  import ebp_pkg::*;
(
  input wire ebp_pins_s pins,
  input wire logic trip,
  output logic fault_input,
  output logic [3:0] gate
);
  // Undriven gates fall to the board pull-down so a released pin keeps its switch off
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = pins.oe[i] ? pins.out[i] : 1'b0;
    end
  end
  // Overcurrent trip stays asserted as a level for as long as the bench commands it
  assign fault_input = trip;
endmodule
`default_nettype wire

//--- test/test_enhanced_bridge_pwm.sv
`timescale 1ns/1ps
`include "ebp_params.svh"
`default_nettype none
module test_enhanced_bridge_pwm;
  import ebp_pkg::*;
  localparam logic [7:0] A_DUTY = `EBP_OFS_DUTY_LOW;
  localparam logic [7:0] A_CTRL = `EBP_OFS_CTRL;
  localparam logic [7:0] A_SHAD = `EBP_OFS_SHADOW;
  localparam logic [7:0] A_SHUT = `EBP_OFS_SHUTDOWN;
  localparam logic [7:0] A_DEL = `EBP_OFS_DELAY;
  localparam logic [7:0] A_TC = `EBP_OFS_TCTL;
  localparam logic [1:0] OK = `EBP_RESP_OKAY;
  localparam logic [1:0] ERR = `EBP_RESP_SLVERR;
  localparam int SETTLE = 192;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic comp1_in = 1'b0, comp2_in = 1'b0, trip = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fault_input;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] gate;
  ebp_pins_s pins;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_rs[$];
  logic [1:0] exp_b[$];
  logic [7:0] rst_ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [7:0] rst_val[8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] cfg_ctl[2] = '{8'h4c, 8'hcc};
  int cfg_hi[2][4] = '{'{64, 0, 0, 24}, '{0, 24, 64, 0}};

  always #12.5 aclk = ~aclk;

  ebp_bridge_pwm i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .comp1_in(comp1_in), .comp2_in(comp2_in), .fault_input(fault_input), .pins(pins));
  ebp_switch_model i_switch (.pins(pins), .trip(trip), .fault_input(fault_input), .gate(gate));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ready is read mid-cycle: inputs only move at rising edges, so it equals the sampled value
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad, wd, t;
    ad = 1'b0;
    wd = 1'b0;
    exp_b.push_back(er);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      if (awready === 1'b1) ad = 1'b1;
      if (wready === 1'b1) wd = 1'b1;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      t = (bvalid === 1'b1);
      @(posedge aclk);
    end while (!t);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic t;
    exp_rd.push_back({24'h0, d});
    exp_rs.push_back(er);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = (arready === 1'b1);
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = (rvalid === 1'b1);
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask

  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) check({30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (rvalid === 1'b1 && rready) begin
      check(rdata, exp_rd.pop_front());
      check({30'h0, rresp}, {30'h0, exp_rs.pop_front()});
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Any window of one whole period holds exactly one period's worth of active time
  task automatic cnt(input int i, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (gate[i] === 1'b1) c++;
    end
    @(posedge aclk);
  endtask

  task automatic set_src(input int i, input logic v);
    case (i)
      0: comp1_in <= v;
      1: comp2_in <= v;
      default: trip <= v;
    endcase
  endtask

  initial begin
    int c, m;
    logic [7:0] r, sd;
    void'($urandom(32'hea057911));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rst_ofs[k]) rd(rst_ofs[k], rst_val[k], OK);
    rd(8'h20, 8'h00, ERR);
    wr(8'h20, 8'h5a, ERR);
    r = 8'($urandom());
    wr(A_DUTY, r, OK);
    rd(A_DUTY, r, OK);
    wr(A_SHAD, ~r, OK);
    rd(A_SHAD, 8'h00, OK);
    wr(8'h08, 8'h0f, OK);
    wr(A_CTRL, 8'h0c, OK);
    wr(A_DUTY, 8'h08, OK);
    for (int ps = 0; ps < 3; ps++) begin
      m = 1 << (2 * ps);
      wr(A_TC, 8'h04 | 8'(ps), OK);
      cyc(3 * 64 * m);
      cnt(0, 64 * m, c);
      check(c, 32 * m);
    end
    rd(A_SHAD, 8'h08, OK);
    wr(A_TC, 8'h04, OK);
    wr(A_DUTY, 8'h20, OK);
    cyc(SETTLE);
    cnt(0, 64, c);
    check(c, 64);
    wr(A_DUTY, 8'h04, OK);
    wr(A_CTRL, 8'h0f, OK);
    cyc(SETTLE);
    cnt(0, 64, c);
    check(c, 48);
    wr(A_DUTY, 8'h06, OK);
    wr(A_DEL, 8'h02, OK);
    wr(A_CTRL, 8'h8c, OK);
    cyc(SETTLE);
    cnt(0, 64, c);
    check(c, 16);
    cnt(1, 64, c);
    check(c, 32);
    wr(A_DEL, 8'h08, OK);
    cyc(SETTLE);
    cnt(0, 64, c);
    check(c, 0);
    cnt(1, 64, c);
    check(c, 8);
    for (int k = 1; k >= 0; k--) begin
      wr(A_CTRL, cfg_ctl[k], OK);
      cyc(SETTLE);
      for (int p = 0; p < 4; p++) begin
        cnt(p, 64, c);
        check(c, cfg_hi[k][p]);
      end
    end
    // A low clock enable must hold the pins across a span longer than the D low phase
    ce <= 1'b0;
    @(negedge aclk);
    sd = {4'h0, gate};
    cyc(48);
    check({28'h0, gate}, {24'h0, sd});
    ce <= 1'b1;
    wr(A_SHUT, 8'h04, OK);
    trip <= 1'b1;
    cyc(12);
    rd(A_SHUT, 8'h04, OK);
    trip <= 1'b0;
    wr(A_DEL, 8'h82, OK);
    for (int i = 0; i < 3; i++) begin
      sd = 8'h06 | (8'h10 << i);
      wr(A_SHUT, sd, OK);
      set_src((i + 1) % 3, 1'b1);
      cyc(12);
      rd(A_SHUT, sd, OK);
      set_src((i + 1) % 3, 1'b0);
      set_src(i, 1'b1);
      cyc(12);
      rd(A_SHUT, sd | 8'h80, OK);
      check({28'h0, gate}, 32'h5);
      check({28'h0, pins.oe & 4'ha}, 32'h0);
      set_src(i, 1'b0);
      cyc(12);
      rd(A_SHUT, sd, OK);
    end
    wr(A_DEL, 8'h02, OK);
    wr(A_SHUT, 8'h40, OK);
    trip <= 1'b1;
    cyc(12);
    wr(A_SHUT, 8'h40, OK);
    rd(A_SHUT, 8'hc0, OK);
    trip <= 1'b0;
    cyc(12);
    rd(A_SHUT, 8'hc0, OK);
    check({28'h0, gate}, 32'h0);
    wr(A_SHUT, 8'h40, OK);
    rd(A_SHUT, 8'h40, OK);
    cnt(0, 64, c);
    check(32'(c < 64), 32'h1);
    cnt(0, 64, c);
    check(c, 64);
    give_verdict;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule
`default_nettype wire
